// file: common/sdww_pkg.sv
// Constants for the write-to-write sequencing block
package sdww_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_BEATS  = 4'h8;
  localparam logic [3:0] ADDR_RECOV  = 4'hc;

  // Control field positions
  localparam int CTRL_BL_LSB  = 0;
  localparam int CTRL_PRE2    = 2;
  localparam int CTRL_ADDLAT_LSB = 8;
  localparam int CTRL_WRLAT_LSB  = 16;
  localparam int LAT_W        = 5;

  // Status bit positions
  localparam int ST_SPACING = 0;
  localparam int ST_CFG     = 1;
  localparam int ST_BUSY    = 2;
  localparam int ST_OVF     = 3;

  // Reset values
  localparam logic [1:0]       BL_RESET  = 2'h0;
  localparam logic [LAT_W-1:0] ADDLAT_RESET = 5'h00;
  localparam logic [LAT_W-1:0] WRLAT_RESET  = 5'h09;

  // Burst-length field encodings
  typedef enum logic [1:0] {
    SDWW_BL_FIXED8 = 2'b00,
    SDWW_BL_PERCMD = 2'b01,
    SDWW_BL_FIXED4 = 2'b10,
    SDWW_BL_RSVD   = 2'b11
  } sdww_bl_e;

  // Beat counts and timing counts in link clocks
  localparam logic [4:0] BEATS_LONG    = 5'h08;
  localparam logic [4:0] BEATS_CHOP    = 5'h04;
  localparam logic [3:0] BAD_GAP_PRE2  = 4'h5;
  localparam logic [LAT_W-1:0] WRLAT_LOWEST = 5'h09;
endpackage

// file: verilog/sdww_fifo.sv
// Synchronous FIFO for captured write beats
module sdww_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,      // Core clock
  input  wire logic             rst_i,      // Synchronous reset
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data
  input  wire logic             in_valid_i, // Write request
  output logic                  in_ready_o, // Not full
  output logic [WIDTH-1:0]      out_data_o, // Head word
  output logic                  out_valid_o,// Not empty
  input  wire logic             out_ready_i // Pop
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("sdww_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  AST_FIFO_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
    else $error("FIFO level beyond depth");
endmodule

// file: verilog/sdww_core.sv
// Write burst sequencer: command latency, burst length, beat capture
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
module sdww_core #(
  parameter int DQ_W       = 8,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic            clk_i,       // 125 MHz core clock
  input  wire logic            rst_i,       // Synchronous reset
  input  wire logic            ck_i,        // Link clock from controller
  input  wire logic            wr_cmd_i,    // Write command, ck sampled
  input  wire logic            chop_sel_i,  // Chop select address bit
  input  wire logic            dqs_i,       // Data strobe
  input  wire logic [DQ_W-1:0] dq_i,        // Write data
  input  wire logic            wb_cyc_i,    // Wishbone cycle
  input  wire logic            wb_stb_i,    // Wishbone strobe
  input  wire logic            wb_we_i,     // Wishbone write
  input  wire logic [3:0]      wb_adr_i,    // Byte address
  input  wire logic [3:0]      wb_sel_i,    // Byte lanes
  input  wire logic [31:0]     wb_dat_i,    // Write data
  output logic [31:0]          wb_dat_o,    // Read data
  output logic                 wb_ack_o,    // Acknowledge
  output logic [DQ_W-1:0]      beat_data_o, // Captured beat
  output logic                 beat_valid_o,// Beat available
  input  wire logic            beat_ready_i,// Beat taken
  output logic                 recov_start_o// Recovery start pulse
);
  localparam int SR_W = 64;

  initial begin
    if (DQ_W < 1 || DQ_W > 32)
      $error("sdww_core: DQ_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Link input synchronisers
  localparam int SY_W = DQ_W + 4;
  logic [SY_W-1:0] s1_reg, s2_reg, s3_reg;
  logic            ck_lvl_reg, dqs_lvl_reg;

  function automatic logic rise_f(input logic a, input logic b,
                                  input logic lvl);
    rise_f = a && b && !lvl;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {dq_i, dqs_i, chop_sel_i, wr_cmd_i, ck_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic ck_rise, dqs_edge;
  logic cmd_s, chop_s;
  logic [DQ_W-1:0] dq_s;
  assign ck_rise  = rise_f(s2_reg[0], s3_reg[0], ck_lvl_reg);
  assign dqs_edge = (s2_reg[3] == s3_reg[3]) && (s3_reg[3] != dqs_lvl_reg);
  assign cmd_s    = s3_reg[1];
  assign chop_s   = s3_reg[2];
  assign dq_s     = s3_reg[SY_W-1:4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_lvl_reg  <= 1'b0;
      dqs_lvl_reg <= 1'b0;
    end else begin
      if (s2_reg[0] == s3_reg[0]) begin
        ck_lvl_reg <= s3_reg[0];
      end
      if (s2_reg[3] == s3_reg[3]) begin
        dqs_lvl_reg <= s3_reg[3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and status registers
  logic [1:0]       bl_reg;
  logic             pre2_reg;
  logic [4:0]       addlat_reg;
  logic [4:0]       wrlat_reg;
  logic             spacing_err_reg;
  logic             ovf_reg;
  logic [15:0]      beats_cnt_reg;
  logic [15:0]      tick_reg;
  logic [15:0]      recov_tick_reg;
  logic [4:0]       beats_left_reg;
  logic             cfg_err;
  logic             wb_req;
  logic             wb_wr;

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i;
  // Too-low latency with the longer preamble is flagged
  assign cfg_err = pre2_reg &&
                   (wrlat_reg <= sdww_pkg::WRLAT_LOWEST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bl_reg   <= sdww_pkg::BL_RESET;
      pre2_reg <= 1'b0;
      addlat_reg <= sdww_pkg::ADDLAT_RESET;
      wrlat_reg  <= sdww_pkg::WRLAT_RESET;
    end else if (wb_wr && wb_adr_i == sdww_pkg::ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        bl_reg   <= wb_dat_i[sdww_pkg::CTRL_BL_LSB +: 2];
        pre2_reg <= wb_dat_i[sdww_pkg::CTRL_PRE2];
      end
      if (wb_sel_i[1]) begin
        addlat_reg <= wb_dat_i[sdww_pkg::CTRL_ADDLAT_LSB +: sdww_pkg::LAT_W];
      end
      if (wb_sel_i[2]) begin
        wrlat_reg <= wb_dat_i[sdww_pkg::CTRL_WRLAT_LSB +: sdww_pkg::LAT_W];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          sdww_pkg::ADDR_CTRL: begin
            wb_dat_o <= {11'h0, wrlat_reg, 3'h0, addlat_reg, 5'h0,
                         pre2_reg, bl_reg};
          end
          sdww_pkg::ADDR_STATUS: begin
            wb_dat_o <= {28'h0, ovf_reg, beats_left_reg != 5'h0, cfg_err,
                         spacing_err_reg};
          end
          sdww_pkg::ADDR_BEATS: begin
            wb_dat_o <= {16'h0, beats_cnt_reg};
          end
          sdww_pkg::ADDR_RECOV: begin
            wb_dat_o <= {16'h0, recov_tick_reg};
          end
          default: begin
            wb_dat_o <= 32'h0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode and latency pipeline
  logic             cmd_take;
  logic             cmd_long;
  logic [5:0]       lat;
  logic [5:0]       lat_m1;
  logic [SR_W-1:0]  start_sr_reg;
  logic [SR_W-1:0]  len_sr_reg;
  logic [3:0]       gap_reg;
  logic             start_now;

  function automatic logic is_long_f(input logic [1:0] field,
                                     input logic chop);
    case (field)
      sdww_pkg::SDWW_BL_FIXED8: is_long_f = 1'b1;
      sdww_pkg::SDWW_BL_PERCMD: is_long_f = chop;
      sdww_pkg::SDWW_BL_FIXED4: is_long_f = 1'b0;
      default:                  is_long_f = 1'b1;
    endcase
  endfunction

  assign cmd_take  = ck_rise && cmd_s;
  assign cmd_long  = is_long_f(bl_reg, chop_s);
  assign lat       = {1'b0, addlat_reg} + {1'b0, wrlat_reg};
  assign lat_m1    = (lat == 6'h0) ? 6'h0 : lat - 6'h1;
  assign start_now = ck_rise && start_sr_reg[0];

  // One slot per link clock, so overlapping bursts keep own latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_sr_reg <= '0;
      len_sr_reg   <= '0;
    end else if (ck_rise) begin
      start_sr_reg <= (start_sr_reg >> 1) |
                      (cmd_s ? (SR_W'(1) << lat_m1) : '0);
      len_sr_reg   <= (len_sr_reg >> 1) |
                      ((cmd_s && cmd_long) ? (SR_W'(1) << lat_m1) : '0);
    end
  end

  // Link-clock spacing since the previous write, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_reg <= 4'hf;
    end else if (ck_rise) begin
      if (cmd_s) begin
        gap_reg <= 4'h1;
      end else if (gap_reg != 4'hf) begin
        gap_reg <= gap_reg + 4'h1;
      end
    end
  end

  logic st_clr_spc, st_clr_ovf, spc_set;
  assign st_clr_spc = wb_wr && wb_adr_i == sdww_pkg::ADDR_STATUS &&
                      wb_sel_i[0] && wb_dat_i[sdww_pkg::ST_SPACING];
  assign st_clr_ovf = wb_wr && wb_adr_i == sdww_pkg::ADDR_STATUS &&
                      wb_sel_i[0] && wb_dat_i[sdww_pkg::ST_OVF];
  assign spc_set    = cmd_take && pre2_reg &&
                      gap_reg == sdww_pkg::BAD_GAP_PRE2;

  // Set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spacing_err_reg <= 1'b0;
    end else if (spc_set) begin
      spacing_err_reg <= 1'b1;
    end else if (st_clr_spc) begin
      spacing_err_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Beat capture and recovery point
  logic [4:0] add_beats;
  logic       cap;
  logic       fifo_ready;
  logic       pend_reg;
  logic       last_cap;

  assign add_beats = start_now ? (len_sr_reg[0] ? sdww_pkg::BEATS_LONG
                                                : sdww_pkg::BEATS_CHOP) : 5'h0;
  // Each strobe edge is one beat, so a clock carries two
  assign cap       = dqs_edge && (beats_left_reg != 5'h0 || start_now);
  assign last_cap  = cap && (beats_left_reg + add_beats == 5'h1);
  assign recov_start_o = ck_rise && pend_reg && beats_left_reg == 5'h0 &&
                         !start_now;

  // A new burst simply adds on, so four-clock spacing runs seamless
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beats_left_reg <= 5'h0;
    end else begin
      beats_left_reg <= beats_left_reg + add_beats -
                        (cap ? 5'h1 : 5'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
    end else if (last_cap) begin
      pend_reg <= 1'b1;
    end else if (recov_start_o || start_now) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg       <= 16'h0;
      recov_tick_reg <= 16'h0;
      beats_cnt_reg  <= 16'h0;
    end else begin
      if (ck_rise) begin
        tick_reg <= tick_reg + 16'h1;
      end
      if (recov_start_o) begin
        recov_tick_reg <= tick_reg;
      end
      if (cap) begin
        beats_cnt_reg <= beats_cnt_reg + 16'h1;
      end
    end
  end

  // The link cannot be stalled; a full FIFO drops the beat and flags it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else if (cap && !fifo_ready) begin
      ovf_reg <= 1'b1;
    end else if (st_clr_ovf) begin
      ovf_reg <= 1'b0;
    end
  end

  sdww_fifo #(
    .WIDTH (DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (dq_s),
    .in_valid_i  (cap),
    .in_ready_o  (fifo_ready),
    .out_data_o  (beat_data_o),
    .out_valid_o (beat_valid_o),
    .out_ready_i (beat_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_LONG_LOAD: assert property (
    start_now && len_sr_reg[0] && beats_left_reg == 5'h0 |=>
    beats_left_reg == ($past(dqs_edge) ? sdww_pkg::BEATS_LONG - 5'h1
                                       : sdww_pkg::BEATS_LONG))
    else $error("Eight-beat burst not loaded");
  AST_PERCMD_CHOP: assert property (
    cmd_take && bl_reg == sdww_pkg::SDWW_BL_PERCMD && !chop_s |=>
    !len_sr_reg[$past(lat_m1)])
    else $error("Per-command chop not applied");
  AST_FIXED_CHOP: assert property (
    cmd_take && bl_reg == 2'b10 |=> !len_sr_reg[$past(lat_m1)])
    else $error("Fixed chop ran eight beats");
  AST_CFG_FLAG: assert property (
    pre2_reg && wrlat_reg == sdww_pkg::WRLAT_LOWEST |-> cfg_err)
    else $error("Forbidden latency not flagged");
  AST_SPACING: assert property (
    cmd_take && pre2_reg && gap_reg == 4'h5 |=> spacing_err_reg [*2])
    else $error("Five-clock spacing not flagged");
  AST_RECOV: assert property (
    recov_start_o |-> $past(pend_reg) && beats_left_reg == 5'h0 && ck_rise)
    else $error("Recovery start at wrong edge");
  AST_B2B: assert property (
    start_now && beats_left_reg == 5'h0 |=> beats_left_reg != 5'h0)
    else $error("Back-to-back burst lost");
  AST_LATENCY: assert property (
    cmd_take && lat > 6'h1 |=> start_sr_reg[$past(lat_m1)])
    else $error("Burst not scheduled at latency");
  AST_STROBE: assert property (
    cap |-> dqs_edge ##1 beats_cnt_reg == $past(beats_cnt_reg) + 16'h1)
    else $error("Beat taken off strobe");

  COV_LONG: cover property (start_now && len_sr_reg[0]);
  COV_CHOP: cover property (start_now && !len_sr_reg[0]);
  COV_SEAMLESS: cover property (start_now && beats_left_reg != 5'h0);
  COV_RECOV: cover property (recov_start_o);
endmodule

// file: tb/sdww_ctl_model.sv
// Controller model: free link clock, write commands, strobe, data
module sdww_ctl_model (
  input  wire logic       clk_i,      // Core clock
  input  wire logic [5:0] tot_lat_i,  // Total write latency in ck
  output logic            ck_o,       // Link clock
  output logic            wr_cmd_o,   // Write command
  output logic            chop_sel_o, // Chop select address bit
  output logic            dqs_o,      // Data strobe
  output logic [7:0]      dq_o,       // Write data
  output logic [11:0]     h_o         // Ck half-period count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_reg = 3'h0;
  bit         plan [0:4095];
  logic [7:0] pd   [0:4095];
  initial begin
    ck_o = 1'b1;
    wr_cmd_o = 1'b0;
    chop_sel_o = 1'b0;
    dqs_o = 1'b0;
    dq_o = 8'h00;
    h_o = 12'h000;
  end
  ////////////////////////////////////////
  always @(posedge clk_i) begin
    ph_reg <= (ph_reg == 3'h4) ? 3'h0 : ph_reg + 3'h1;
    // Data settles two clocks ahead; idle bus keeps changing
    if (ph_reg == 3'h2) begin
      dq_o <= plan[h_o+12'h1] ? pd[h_o+12'h1] : ~dq_o;
    end
    if (ph_reg == 3'h4) begin
      ck_o <= ~ck_o;
      h_o  <= h_o + 12'h1;
      if (plan[h_o+12'h1]) begin
        dqs_o <= ~dqs_o;
      end
    end
  end
  ////////////////////////////////////////
  task automatic fall_edge();
    do @(posedge clk_i); while (!(ph_reg == 3'h4 && ck_o === 1'b1));
  endtask
  // Command after skip ck falls; always eight beats of data
  task automatic issue(input int skip, input logic chop,
                       input logic [7:0] base, output int hc);
    int i;
    for (i = 0; i < skip; i++) fall_edge();
    wr_cmd_o   <= 1'b1;
    chop_sel_o <= chop;
    hc = int'(h_o) + 2;
    for (i = 0; i < 8; i++) begin
      plan[hc+2*tot_lat_i+i] = 1'b1;
      pd[hc+2*tot_lat_i+i]   = base + i[7:0];
    end
    fall_edge();
    wr_cmd_o   <= 1'b0;
    chop_sel_o <= ~chop;
  endtask
endmodule

// file: tb/sdww_tb_top.sv
// Testbench: burst lengths, latency, spacing, FIFO, registers
module sdww_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  bdat;
  logic        bval;
  logic        brdy = 1'b0;
  logic        recov;
  logic        ck, cmd, chop, dqs;
  logic [7:0]  dq;
  logic [11:0] h;
  logic [5:0]  tot_lat = 6'h09;
  int          err_count = 0;
  int          compares = 0;
  always #4 clk_i = ~clk_i;
  sdww_core #(.DQ_W(8), .FIFO_DEPTH(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ck_i(ck), .wr_cmd_i(cmd),
    .chop_sel_i(chop), .dqs_i(dqs), .dq_i(dq), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .beat_data_o(bdat), .beat_valid_o(bval), .beat_ready_i(brdy),
    .recov_start_o(recov));
  sdww_ctl_model ctl_u (.clk_i(clk_i), .tot_lat_i(tot_lat), .ck_o(ck),
    .wr_cmd_o(cmd), .chop_sel_o(chop), .dqs_o(dqs), .dq_o(dq), .h_o(h));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic timeout(input string nm);
    err_count++;
    $display("[FAIL] %s expected done seen timeout", nm);
    report_and_stop();
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) timeout("wb_ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  task automatic cfg(input logic [1:0] bl, input logic pre,
                     input logic [4:0] addlat, wrlat);
    logic [31:0] q;
    wb(1'b1, sdww_pkg::ADDR_CTRL,
       {11'h0, wrlat, 3'h0, addlat, 5'h0, pre, bl}, q);
    tot_lat = {1'b0, addlat} + {1'b0, wrlat};
  endtask
  task automatic wait_h(input int t);
    int n;
    for (n = 0; n < 20000 && int'(h) < t; n++) @(posedge clk_i);
    if (int'(h) < t) timeout("link_time");
  endtask
  task automatic wait_recov(output int hp);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (recov !== 1'b1 && n < 3000);
    if (recov !== 1'b1) timeout("recov");
    hp = int'(h);
  endtask
  // Far side stalls until the caller drains
  task automatic drain(input int n, input logic [7:0] base, input string nm);
    int i;
    int t;
    i = 0;
    @(posedge clk_i);
    brdy <= 1'b1;
    for (t = 0; t < 500 && i < n; t++) begin
      @(posedge clk_i);
      if (bval === 1'b1) begin
        check(nm, {24'h0, bdat}, {24'h0, base + i[7:0]});
        i++;
      end
    end
    brdy <= 1'b0;
    check({nm, "_count"}, i, n);
    repeat (2) @(posedge clk_i);
    check({nm, "_empty"}, {31'h0, bval}, 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    rd(sdww_pkg::ADDR_CTRL, {11'h0, sdww_pkg::WRLAT_RESET, 3'h0,
       sdww_pkg::ADDLAT_RESET, 6'h0, sdww_pkg::BL_RESET}, "ctrl_rst");
    rd(sdww_pkg::ADDR_STATUS, 32'h0, "status_rst");
    rd(4'h1, 32'h0, "unmapped");
    cfg(2'h2, 1'b0, 5'h03, 5'h0a);
    wb(1'b1, 4'h1, 32'hffff_ffff, q);
    rd(sdww_pkg::ADDR_CTRL, 32'h000a_0302, "ctrl_back");
    $display("Test regs done");
  endtask
  task automatic t_len();
    logic [1:0] fld [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic       sel [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int         nb  [5] = '{8, 8, 4, 4, 8};
    int         i;
    int         hc;
    int         hp;
    for (i = 0; i < 5; i++) begin
      // Latency varies per mode to catch a fixed offset
      cfg(fld[i], 1'b0, i[4:0], 5'h09 + {4'h0, i[0]});
      ctl_u.issue(1, sel[i], 8'h20 * i[7:0], hc);
      wait_recov(hp);
      check("recov_edge", hp,
            hc + 2 * int'(tot_lat) + nb[i]);
      wait_h(hc + 2 * int'(tot_lat) + 10);
      drain(nb[i], 8'h20 * i[7:0], "burst");
    end
    $display("Test lengths done");
  endtask
  task automatic t_b2b();
    logic [31:0] q;
    int          hc;
    int          hp;
    cfg(2'h0, 1'b0, 5'h00, 5'h09);
    ctl_u.issue(1, 1'b1, 8'h40, hc);
    ctl_u.issue(3, 1'b1, 8'h48, hc);
    ctl_u.issue(3, 1'b1, 8'h50, hc);
    wait_recov(hp);
    check("b2b_recov", hp, hc + 2 * int'(tot_lat) + 8);
    wait_h(hc + 2 * int'(tot_lat) + 10);
    rd(sdww_pkg::ADDR_STATUS, 32'h8, "ovf_set");
    drain(16, 8'h40, "b2b");
    rd(sdww_pkg::ADDR_BEATS, 32'h38, "beats_cnt");
    wb(1'b1, sdww_pkg::ADDR_STATUS, 32'h8, q);
    rd(sdww_pkg::ADDR_STATUS, 32'h0, "ovf_clr");
    $display("Test back-to-back done");
  endtask
  task automatic t_pre();
    logic [31:0] q;
    int          hc;
    cfg(2'h0, 1'b1, 5'h00, 5'h09);
    rd(sdww_pkg::ADDR_STATUS, 32'h2, "cfg_bad");
    cfg(2'h0, 1'b1, 5'h00, 5'h0a);
    rd(sdww_pkg::ADDR_STATUS, 32'h0, "cfg_ok");
    ctl_u.issue(1, 1'b1, 8'h00, hc);
    ctl_u.issue(5, 1'b1, 8'h08, hc);
    wait_h(hc + 2 * int'(tot_lat) + 10);
    rd(sdww_pkg::ADDR_STATUS, 32'h0, "gap6");
    drain(16, 8'h00, "gap6");
    ctl_u.issue(1, 1'b1, 8'h60, hc);
    ctl_u.issue(4, 1'b1, 8'h68, hc);
    wait_h(hc + 2 * int'(tot_lat) + 10);
    rd(sdww_pkg::ADDR_STATUS, 32'h1, "gap5");
    drain(16, 8'h60, "gap5");
    wb(1'b1, sdww_pkg::ADDR_STATUS, 32'h1, q);
    rd(sdww_pkg::ADDR_STATUS, 32'h0, "gap_clr");
    $display("Test preamble done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_len();
    t_b2b();
    t_pre();
    report_and_stop();
  end
endmodule
